// *** rtl/rms_top.v ***
// radio receive sequencing, transmit shaping and synthesizer core
//
// Notes on behaviour
// (RULE1) controller sets receive enable, clears others, then raises cycle enable
// (RULE2) controller sets transmit and narrow band, clears receive, then enables
// (RULE3) receive: filter on after 10 us, tuning done after 140 us
// (RULE4) filter off at once when enable falls; off in idle and transmit
// (RULE5) 4-bit strength readable at index 29 in idle when both enables set
// (RULE6) strength value refreshed 40 us after first receive bit
// (RULE7) 6-bit two's-complement samples sent serially, six bits per sample
// (RULE8) device forwards data clock with samples; controller makes word start
// (RULE9) transmit waits programmed microsecond delay before first bit
// (RULE10) antenna data enabled 2.5 us after launch delay expires
// (RULE11) controller packets start with four alternating preamble bits
// (RULE12) controller keeps launch delay minimal unless settling needed
// (RULE13) oscillator divider driven by three cascaded accumulators
// (RULE14) controller computes integer and fraction words from LO
// (RULE15) controller uses 157500 Hz deviation in its calculations
// (RULE16) trajectory picked from current bit and two previous bits
// (RULE17) eleven coefficients, trajectories folded into one quadrant
// (RULE18) table drives accumulators; seven top bits drive second port
// (RULE19) receive holds table output at first coefficient entry
// (RULE20) controller rounds coefficients by adding 2 and dividing by 4
// (RULE21) controller uses the fixed trajectory constants
// (RULE22) table output scaled by slope and intercept before the DAC
// (RULE23) controller programs slope and intercept from reference ratio
// (RULE24) launch delay counted in microsecond ticks from enable rise
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rms_map.vh"
module rms_top (
  input wire clk,
  input wire rst_n,
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire radio_cycle_enable,
  input wire tx_data,
  input wire data_clk,
  input wire [5:0] adc_sample,
  input wire [3:0] signal_strength_value_adc,
  output reg if_channel_filter_en,
  output reg if_filter_tune_done,
  output reg tx_bit_req,
  output reg tx_antenna_en,
  output reg [8:0] shaping_word,
  output reg [6:0] vco_port2,
  output reg [8:0] mod_dac,
  output reg [10:0] synth_div,
  output reg rx_serial_data,
  output reg rx_serial_clk
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RX = 3'b010;
  localparam ST_TX = 3'b100;

  reg [15:0] mode_r;
  reg [15:0] signal_strength_value_ctl_r;
  reg [15:0] txdly_r;
  reg [15:0] signal_strength_value_rd_r;
  reg [9:0] syn_int_r;
  reg [15:0] syn_frac_r;
  reg [7:0] slope_r;
  reg [12:0] s1_r;
  reg [12:0] s2_r;
  reg en_d_r;
  reg dclk_d_r;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [11:0] rx_cnt_r;
  reg [2:0] bit_idx_r;
  reg [5:0] sr_r;
  reg first_bit_r;
  reg [9:0] signal_strength_value_cnt_r;
  reg signal_strength_value_run_r;
  reg [3:0] signal_strength_value_val_r;
  reg [4:0] us_div_r;
  reg [7:0] us_cnt_r;
  reg launch_r;
  reg [5:0] ant_cnt_r;
  reg [2:0] hist_r;
  reg sign_r;
  reg [15:0] acc1_r;
  reg [15:0] acc2_r;
  reg [15:0] acc3_r;
  reg c1_r;
  reg c2_r;
  reg c3_r;
  reg c2d_r;
  reg c3d_r;
  reg c3dd_r;

  wire en_s = s2_r[12];
  wire tx_s = s2_r[11];
  wire dclk_s = s2_r[10];
  wire [5:0] adc_s = s2_r[9:4];
  wire [3:0] signal_strength_value_s = s2_r[3:0];
  wire en_rise = en_s & ~en_d_r;
  wire dclk_rise = dclk_s & ~dclk_d_r;
  wire us_tick = (us_div_r == (`RMS_CYC_US - 1));
  wire [7:0] dly = txdly_r[`RMS_F_DLY_HI:`RMS_F_DLY_LO];
  wire [7:0] icpt = txdly_r[7:0];
  wire [7:0] coef;
  wire coef_wr;
  reg [3:0] coef_idx;

  // sample column of a microsecond bit
  function [1:0] col_of;
    input [4:0] div;
    begin
      if (div < `RMS_PH1)
        col_of = 2'h0;
      else if (div < `RMS_PH2)
        col_of = 2'h1;
      else if (div < `RMS_PH3)
        col_of = 2'h2;
      else
        col_of = 2'h3;
    end
  endfunction

  // folded quadrant lookup: history {oldest, prev, current}
  function [3:0] fold_idx;
    input [2:0] h;
    input [1:0] col;
    begin
      if (h[2] == h[1] && h[1] == h[0])
        fold_idx = 4'h0;
      else if (h[1] == h[0])
        fold_idx = (col == 2'h0) ? 4'h0 : {2'b00, col};
      else if (h[2] == h[1])
        fold_idx = 4'h4 + {2'b00, col};
      else
        fold_idx = (col == 2'h0) ? 4'h4 : (4'h7 + {2'b00, col});
    end
  endfunction

  // two-flop synchronisers for the enable, data, clock, sample and strength pins
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 13'h0000;
      s2_r <= 13'h0000;
      en_d_r <= 1'b0;
      dclk_d_r <= 1'b0;
    end
    else
    begin
      s1_r <= {radio_cycle_enable, tx_data, data_clk, adc_sample, signal_strength_value_adc};
      s2_r <= s1_r;
      en_d_r <= en_s;
      dclk_d_r <= dclk_s;
    end
  end

  // register writes
  assign coef_wr = reg_wr && reg_addr >= `RMS_REG_COEF_LO &&
                   reg_addr <= `RMS_REG_COEF_HI;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r <= `RMS_RST_MODE;
      signal_strength_value_ctl_r <= `RMS_RST_SIGNAL_STRENGTH_VALUE_CTL;
      txdly_r <= `RMS_RST_TXDLY;
      signal_strength_value_rd_r <= `RMS_RST_SIGNAL_STRENGTH_VALUE_RD;
      syn_int_r <= `RMS_RST_SYN_INT;
      syn_frac_r <= `RMS_RST_SYN_FRAC;
      slope_r <= `RMS_RST_SLOPE;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `RMS_REG_MODE: mode_r <= reg_wdata;
        `RMS_REG_SIGNAL_STRENGTH_VALUE_CTL: signal_strength_value_ctl_r <= reg_wdata;
        `RMS_REG_TXDLY: txdly_r <= reg_wdata;
        `RMS_REG_SIGNAL_STRENGTH_VALUE_RD: signal_strength_value_rd_r <= reg_wdata;
        `RMS_REG_SYN_INT: syn_int_r <= reg_wdata[9:0];
        `RMS_REG_SYN_FRAC: syn_frac_r <= reg_wdata;
        `RMS_REG_COEF_HI: slope_r <= reg_wdata[15:8];
        default: slope_r <= slope_r;
      endcase
    end
  end

  // register reads, data one cycle after the strobe
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `RMS_REG_MODE: reg_rdata <= mode_r;
        `RMS_REG_SIGNAL_STRENGTH_VALUE_CTL: reg_rdata <= signal_strength_value_ctl_r;
        `RMS_REG_TXDLY: reg_rdata <= txdly_r;
        `RMS_REG_SIGNAL_STRENGTH_VALUE_RD: reg_rdata <= signal_strength_value_rd_r;
        `RMS_REG_SYN_INT: reg_rdata <= {6'h00, syn_int_r};
        `RMS_REG_SYN_FRAC: reg_rdata <= syn_frac_r;
        `RMS_REG_SIGNAL_STRENGTH_VALUE: reg_rdata <= (st_r == ST_IDLE &&
          signal_strength_value_ctl_r[`RMS_B_SIGNAL_STRENGTH_VALUE_EN] && signal_strength_value_rd_r[`RMS_B_SIGNAL_STRENGTH_VALUE_RDEN]) ?
          {12'h000, signal_strength_value_val_r} : 16'h0000; // [RULE5]
        `RMS_REG_STATUS: reg_rdata <= {11'h000, launch_r,
          if_filter_tune_done, if_channel_filter_en, st_r[2], st_r[1]};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // cycle state: mode chosen on enable rise, idle on fall
  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:
        if (en_rise && mode_r[`RMS_B_RXEN] && !mode_r[`RMS_B_TXEN] &&
            !mode_r[`RMS_B_NBW])
          st_nxt = ST_RX;
        else if (en_rise && mode_r[`RMS_B_TXEN] && mode_r[`RMS_B_NBW] &&
                 !mode_r[`RMS_B_RXEN])
          st_nxt = ST_TX;
      ST_RX:
        if (!en_s)
          st_nxt = ST_IDLE;
      ST_TX:
        if (!en_s)
          st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= ST_IDLE;
    else
      st_r <= st_nxt;
  end

  // receive timer, filter enable and tuning flag
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_cnt_r <= 12'h000;
      if_channel_filter_en <= 1'b0;
      if_filter_tune_done <= 1'b0;
    end
    else
    begin
      if (st_nxt != ST_RX)
        rx_cnt_r <= 12'h000;
      else if (rx_cnt_r != `RMS_CYC_TUNE)
        rx_cnt_r <= rx_cnt_r + 12'h001;
      if_channel_filter_en <= (st_nxt == ST_RX) &&
        (rx_cnt_r >= `RMS_CYC_FILT - 1); // [RULE3] [RULE4]
      if_filter_tune_done <= (st_nxt == ST_RX) &&
        (rx_cnt_r >= `RMS_CYC_TUNE - 1); // [RULE3] [RULE4]
    end
  end

  // serial sample output on each data clock rise, MSB first
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_idx_r <= 3'h0;
      sr_r <= 6'h00;
      rx_serial_data <= 1'b0;
      rx_serial_clk <= 1'b0;
      first_bit_r <= 1'b0;
    end
    else
    begin
      rx_serial_clk <= dclk_s & (st_r == ST_RX); // [RULE8]
      if (st_r != ST_RX)
      begin
        bit_idx_r <= 3'h0;
        rx_serial_data <= 1'b0;
        first_bit_r <= 1'b0;
      end
      else if (dclk_rise)
      begin
        first_bit_r <= 1'b1;
        if (bit_idx_r == 3'h0)
        begin
          rx_serial_data <= adc_s[5]; // [RULE7]
          sr_r <= {adc_s[4:0], 1'b0};
        end
        else
        begin
          rx_serial_data <= sr_r[5];
          sr_r <= {sr_r[4:0], 1'b0};
        end
        bit_idx_r <= (bit_idx_r == 3'h5) ? 3'h0 : bit_idx_r + 3'h1;
      end
    end
  end

  // strength refresh a fixed time after the first receive bit
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      signal_strength_value_cnt_r <= 10'h000;
      signal_strength_value_run_r <= 1'b0;
      signal_strength_value_val_r <= 4'h0;
    end
    else if (st_r == ST_RX && dclk_rise && !first_bit_r)
    begin
      signal_strength_value_cnt_r <= 10'h000;
      signal_strength_value_run_r <= 1'b1;
    end
    else if (signal_strength_value_run_r)
    begin
      if (signal_strength_value_cnt_r == `RMS_CYC_SIGNAL_STRENGTH_VALUE - 1)
      begin
        signal_strength_value_val_r <= signal_strength_value_s; // [RULE6]
        signal_strength_value_run_r <= 1'b0;
      end
      signal_strength_value_cnt_r <= signal_strength_value_cnt_r + 10'h001;
    end
  end

  // microsecond ticks, launch delay, bit request and antenna enable
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      us_div_r <= 5'h00;
      us_cnt_r <= 8'h00;
      launch_r <= 1'b0;
      ant_cnt_r <= 6'h00;
      tx_antenna_en <= 1'b0;
      tx_bit_req <= 1'b0;
      hist_r <= 3'b000;
    end
    else if (st_r != ST_TX)
    begin
      us_div_r <= 5'h00;
      us_cnt_r <= 8'h00;
      launch_r <= 1'b0;
      ant_cnt_r <= 6'h00;
      tx_antenna_en <= 1'b0;
      tx_bit_req <= 1'b0;
    end
    else
    begin
      us_div_r <= us_tick ? 5'h00 : us_div_r + 5'h01; // [RULE24]
      tx_bit_req <= 1'b0;
      if (!launch_r)
      begin
        if (us_cnt_r == dly)
        begin
          launch_r <= 1'b1; // [RULE9] [RULE24]
          tx_bit_req <= 1'b1;
          us_div_r <= 5'h00;
        end
        else if (us_tick)
          us_cnt_r <= us_cnt_r + 8'h01; // [RULE24]
      end
      else
      begin
        if (ant_cnt_r != `RMS_CYC_ANT)
          ant_cnt_r <= ant_cnt_r + 6'h01;
        tx_antenna_en <= (ant_cnt_r >= `RMS_CYC_ANT - 1); // [RULE10]
        if (us_tick)
          tx_bit_req <= 1'b1;
        if (us_div_r == 5'h00)
          hist_r <= {hist_r[1:0], tx_s}; // [RULE16]
      end
    end
  end

  // table address: folded trajectory in transmit after launch, first entry otherwise
  always @*
  begin
    if (st_r == ST_TX && launch_r)
      coef_idx = fold_idx(hist_r, col_of(us_div_r)); // [RULE16] [RULE17]
    else
      coef_idx = 4'h0; // [RULE19]
  end

  rms_coef_mem u_coef (
    .clk(clk),
    .wr_en(coef_wr),
    .wr_word(reg_addr[2:0] - 3'h4),
    .wr_data(reg_wdata),
    .rd_byte(coef_idx),
    .rd_data(coef)
  );

  // signed shaping word, scaled DAC value and second port
  wire signed [17:0] prod = $signed(shaping_word) * $signed({1'b0, slope_r});
  wire [8:0] scaled = prod[15:7] + {1'b0, icpt};
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sign_r <= 1'b0;
      shaping_word <= 9'h000;
      vco_port2 <= 7'h00;
      mod_dac <= 9'h000;
    end
    else
    begin
      sign_r <= (st_r == ST_TX && launch_r) ? ~hist_r[0] : 1'b0;
      if (st_r == ST_IDLE)
        shaping_word <= 9'h000; // no deviation, table may be unwritten
      else if (sign_r)
        shaping_word <= 9'h000 - {1'b0, coef};
      else
        shaping_word <= {1'b0, coef};
      vco_port2 <= shaping_word[8:2]; // [RULE18]
      mod_dac <= scaled; // [RULE22]
    end
  end

  // three cascaded accumulators with modulated fraction
  wire [15:0] fin = syn_frac_r + {{7{shaping_word[8]}}, shaping_word};
  wire [16:0] a1 = {1'b0, acc1_r} + {1'b0, fin}; // [RULE18]
  wire [16:0] a2 = {1'b0, acc2_r} + {1'b0, a1[15:0]};
  wire [16:0] a3 = {1'b0, acc3_r} + {1'b0, a2[15:0]};
  wire [10:0] div_sum = {1'b0, syn_int_r} + `RMS_SYN_OFS +
    {10'h000, c1_r} + {10'h000, c2_r} + {10'h000, c3_r} +
    {10'h000, c3dd_r} - {10'h000, c2d_r} - {9'h000, c3d_r, 1'b0};
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc1_r <= 16'h0000;
      acc2_r <= 16'h0000;
      acc3_r <= 16'h0000;
      c1_r <= 1'b0;
      c2_r <= 1'b0;
      c3_r <= 1'b0;
      c2d_r <= 1'b0;
      c3d_r <= 1'b0;
      c3dd_r <= 1'b0;
      synth_div <= 11'h000;
    end
    else
    begin
      acc1_r <= a1[15:0]; // [RULE13]
      acc2_r <= a2[15:0];
      acc3_r <= a3[15:0];
      c1_r <= a1[16];
      c2_r <= a2[16];
      c3_r <= a3[16];
      c2d_r <= c2_r;
      c3d_r <= c3_r;
      c3dd_r <= c3d_r;
      synth_div <= div_sum; // [RULE13]
    end
  end
endmodule
`default_nettype wire

// *** rtl/rms_map.vh ***
// register offsets, fields, reset values and timing counts of the radio core
`ifndef RMS_MAP_VH
`define RMS_MAP_VH
// register indices
`define RMS_REG_MODE 5'h02
`define RMS_REG_SIGNAL_STRENGTH_VALUE_CTL 5'h04
`define RMS_REG_TXDLY 5'h08
`define RMS_REG_SIGNAL_STRENGTH_VALUE_RD 5'h09
`define RMS_REG_SYN_INT 5'h0A
`define RMS_REG_SYN_FRAC 5'h0B
`define RMS_REG_COEF_LO 5'h0C
`define RMS_REG_COEF_HI 5'h11
`define RMS_REG_SIGNAL_STRENGTH_VALUE 5'h1D
`define RMS_REG_STATUS 5'h1E
// field positions
`define RMS_B_TXEN 14
`define RMS_B_RXEN 13
`define RMS_B_NBW 12
`define RMS_B_INJ 11
`define RMS_B_SIGNAL_STRENGTH_VALUE_EN 6
`define RMS_B_SIGNAL_STRENGTH_VALUE_RDEN 8
`define RMS_F_DLY_HI 15
`define RMS_F_DLY_LO 8
// reset values
`define RMS_RST_MODE 16'h0000
`define RMS_RST_SIGNAL_STRENGTH_VALUE_CTL 16'h0000
`define RMS_RST_TXDLY 16'h0000
`define RMS_RST_SIGNAL_STRENGTH_VALUE_RD 16'h0000
`define RMS_RST_SYN_INT 10'h0B8
`define RMS_RST_SYN_FRAC 16'h0000
`define RMS_RST_SLOPE 8'h00
// synthesizer integer offset
`define RMS_SYN_OFS 11'h003
// timing, in ns, and counts of 40 ns cycles (rounded up)
`define RMS_CLK_NS 40
`define RMS_T_FILT_NS 10000
`define RMS_T_TUNE_NS 140000
`define RMS_T_SIGNAL_STRENGTH_VALUE_NS 40000
`define RMS_T_ANT_NS 2500
`define RMS_T_US_NS 1000
`define RMS_CYC_FILT ((`RMS_T_FILT_NS + `RMS_CLK_NS - 1) / `RMS_CLK_NS)
`define RMS_CYC_TUNE ((`RMS_T_TUNE_NS + `RMS_CLK_NS - 1) / `RMS_CLK_NS)
`define RMS_CYC_SIGNAL_STRENGTH_VALUE ((`RMS_T_SIGNAL_STRENGTH_VALUE_NS + `RMS_CLK_NS - 1) / `RMS_CLK_NS)
`define RMS_CYC_ANT ((`RMS_T_ANT_NS + `RMS_CLK_NS - 1) / `RMS_CLK_NS)
`define RMS_CYC_US (`RMS_T_US_NS / `RMS_CLK_NS)
// sample phase boundaries inside one microsecond bit
`define RMS_PH1 5'h06
`define RMS_PH2 5'h0C
`define RMS_PH3 5'h13
`endif

// *** rtl/rms_coef_mem.v ***
// shaping coefficient store: word writes, registered byte reads
`timescale 1ns/1ps
`default_nettype none
module rms_coef_mem (
  input wire clk,
  input wire wr_en,
  input wire [2:0] wr_word,
  input wire [15:0] wr_data,
  input wire [3:0] rd_byte,
  output reg [7:0] rd_data
);
  reg [15:0] mem [0:5];
  wire [15:0] rd_word;

  assign rd_word = mem[rd_byte[3:1]];

  // word write from the register port
  always @(posedge clk)
  begin
    if (wr_en)
      mem[wr_word] <= wr_data;
  end

  // byte read, registered
  always @(posedge clk)
  begin
    rd_data <= rd_byte[0] ? rd_word[15:8] : rd_word[7:0];
  end
endmodule
`default_nettype wire

// *** bench/rms_monitor.sv ***
// assertions and covers on the radio core ports
`timescale 1ns/1ps
`default_nettype none
module rms_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic radio_cycle_enable,
  input wire logic if_channel_filter_en,
  input wire logic if_filter_tune_done,
  input wire logic tx_bit_req,
  input wire logic tx_antenna_en,
  input wire logic [8:0] shaping_word,
  input wire logic [6:0] vco_port2
);
  logic [12:0] on_r;
  logic [4:0] gap_r;
  logic seen_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // cycles the enable pin is high, cycles since the last bit request
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_r <= 13'h0000;
      gap_r <= 5'h00;
      seen_r <= 1'b0;
    end
    else
    begin
      on_r <= radio_cycle_enable ? on_r + {12'h000, ~&on_r} : 13'h0000;
      gap_r <= tx_bit_req ? 5'h00 : gap_r + {4'h0, ~&gap_r};
      seen_r <= radio_cycle_enable & (seen_r | tx_bit_req);
    end
  end
  a_filter_time: assert property ($rose(if_channel_filter_en)
    |-> on_r >= 13'h00FA && on_r <= 13'h0102) else $error("filter time");
  a_tune_time: assert property ($rose(if_filter_tune_done)
    |-> on_r >= 13'h0DAC && on_r <= 13'h0DB6) else $error("tune time");
  a_tune_filter: assert property (if_filter_tune_done
    |-> if_channel_filter_en) else $error("tune without filter");
  a_idle_quiet: assert property ((!radio_cycle_enable)[*8]
    |-> !if_channel_filter_en && !if_filter_tune_done && !tx_antenna_en
    && !tx_bit_req) else $error("busy while idle");
  a_filter_tx: assert property (tx_antenna_en
    |-> !if_channel_filter_en) else $error("filter on in transmit");
  a_antenna_lag: assert property ($rose(tx_antenna_en)
    |-> $past(tx_bit_req, 62) || $past(tx_bit_req, 63)
    || $past(tx_bit_req, 64)) else $error("antenna lag");
  a_bit_spacing: assert property (seen_r && tx_bit_req
    |-> gap_r == 5'h18) else $error("bit spacing");
  a_port2_msbs: assert property ($stable(shaping_word) ##1
    $stable(shaping_word) |-> vco_port2 == shaping_word[8:2])
    else $error("port two bits");
  a_rx_hold: assert property (if_channel_filter_en
    && $past(if_channel_filter_en) |-> $stable(shaping_word))
    else $error("table moved in receive");
  c_filter: cover property ($rose(if_channel_filter_en));
  c_tune: cover property ($rose(if_filter_tune_done));
  c_antenna: cover property ($rose(tx_antenna_en));
  c_bits: cover property (seen_r && tx_bit_req);
endmodule
bind rms_top rms_monitor i_rms_monitor (.clk(clk), .rst_n(rst_n),
  .radio_cycle_enable(radio_cycle_enable),
  .if_channel_filter_en(if_channel_filter_en),
  .if_filter_tune_done(if_filter_tune_done), .tx_bit_req(tx_bit_req),
  .tx_antenna_en(tx_antenna_en), .shaping_word(shaping_word),
  .vco_port2(vco_port2));
`default_nettype wire

// *** bench/rms_bb_model.sv ***
// controller model: cycle enable, preamble, link clock, converter values
`timescale 1ns/1ps
`default_nettype none
module rms_bb_model (
  input wire logic clk,
  input wire logic go,
  input wire logic rx_mode,
  input wire logic steady_bit,
  input wire logic tx_bit_req,
  output logic radio_cycle_enable,
  output logic tx_data,
  output var logic data_clk,
  output logic [5:0] adc_sample,
  output logic [3:0] signal_strength_value_adc
);
  logic [7:0] go_d_r = 8'h00;
  logic [2:0] nbits_r = 3'h0;
  // enable raised only once the bench has set the mode bits
  assign radio_cycle_enable = go;
  assign adc_sample = rx_mode ? 6'h2B : 6'h14;
  assign signal_strength_value_adc = go_d_r[7] && rx_mode ? 4'h9 : 4'h3;
  // four alternating preamble bits lead every packet
  assign tx_data = nbits_r < 3'h4 ? ~nbits_r[0] : steady_bit;
  // delayed enable copy and count of preamble bits sent
  always @(posedge clk)
  begin
    go_d_r <= {go_d_r[6:0], go};
    if (!go)
      nbits_r <= 3'h0;
    else if (tx_bit_req && nbits_r < 3'h4)
      nbits_r <= nbits_r + 3'h1;
  end
  // 320 ns link clock, still outside receive frames
  initial
  begin
    data_clk = 1'b0;
    #3;
    forever
    begin
      #160;
      data_clk = go_d_r[7] && rx_mode ? ~data_clk : 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** bench/rms_top_tb.sv ***
// bench for the radio core: registers, receive and transmit cycles
`timescale 1ns/1ps
`default_nettype none
module rms_top_tb;
  logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic go = 1'b0, rxm = 1'b0, stb = 1'b1;
  logic [4:0] adr = 5'h00;
  logic [15:0] wd = 16'h0000, rdat;
  logic en, txd, dck, filt, tune, req, ant, sck, sdat, sck_d;
  logic [5:0] adc, word;
  logic [3:0] rss, nf = 4'h0;
  logic [8:0] shp, dac;
  logic [6:0] vp2;
  logic [10:0] div;
  int n_mismatch = 0, cmp_count = 0, n = 0;
  always #20 clk = ~clk;
  rms_top i_rms_top (.clk(clk), .rst_n(rst_n), .reg_addr(adr),
    .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat),
    .radio_cycle_enable(en), .tx_data(txd), .data_clk(dck),
    .adc_sample(adc), .signal_strength_value_adc(rss), .if_channel_filter_en(filt),
    .if_filter_tune_done(tune), .tx_bit_req(req), .tx_antenna_en(ant),
    .shaping_word(shp), .vco_port2(vp2), .mod_dac(dac), .synth_div(div),
    .rx_serial_data(sdat), .rx_serial_clk(sck));
  rms_bb_model i_rms_bb_model (.clk(clk), .go(go), .rx_mode(rxm),
    .steady_bit(stb), .tx_bit_req(req), .radio_cycle_enable(en),
    .tx_data(txd), .data_clk(dck), .adc_sample(adc), .signal_strength_value_adc(rss));
  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, hi);
    cmp_count++;
    if (n < lo || n > hi)
    begin
      n_mismatch++;
      $display("wrong value %s exp %0d to %0d seen %0d", nm, lo, hi, n);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    adr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk("read data", e, rdat);
  endtask
  // bounded wait for filter, tuning, bit request or antenna
  task automatic wait_on(input int w, input int lim);
    while ((w == 0 ? filt : w == 1 ? tune : w == 2 ? req : ant) !== 1'b1
      && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= lim)
    begin
      n_mismatch++;
      $display("wrong value wait %0d exp 1 seen 0", w);
      tally_and_finish();
    end
  endtask
  // first six serial bits of a cycle, taken on forwarded clock falls
  always @(posedge clk)
  begin
    sck_d <= sck;
    if (!go)
      nf <= 4'h0;
    else if (sck_d && !sck && nf < 4'h6)
    begin
      word <= {word[4:0], sdat};
      nf <= nf + 4'h1;
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("divider", 16'h00BB, {5'h00, div});
    wr(5'h0A, 16'h00B8);
    // table for a 13 MHz reference and 157500 Hz deviation
    wr(5'h0C, 16'hC6C6);
    wr(5'h0D, 16'hC0C5);
    wr(5'h0E, 16'h6825);
    wr(5'h0F, 16'hB498);
    wr(5'h10, 16'h9668);
    wr(5'h11, 16'h6CAD);
    wr(5'h08, 16'h0361);
    wr(5'h04, 16'h0040);
    rd(5'h1D, 16'h0000);
    wr(5'h09, 16'h0100);
    rd(5'h0C, 16'h0000);
    rd(5'h1F, 16'h0000);
    chk("divider idle", 16'h00BB, {5'h00, div});
    // both receive and transmit set: block stays idle
    wr(5'h02, 16'h6000);
    go <= 1'b1;
    repeat (300) @(posedge clk);
    rd(5'h1E, 16'h0000);
    @(posedge clk);
    go <= 1'b0;
    rxm <= 1'b1;
    wr(5'h02, 16'h2000);
    rd(5'h02, 16'h2000);
    @(posedge clk);
    go <= 1'b1;
    n = 0;
    wait_on(0, 400);
    rng("filter delay", 250, 258);
    wait_on(1, 4000);
    rng("tune delay", 3500, 3510);
    rd(5'h1E, 16'h000D);
    rd(5'h1D, 16'h0000);
    chk("serial word", 16'h002B, {10'h000, word});
    chk("rx table", 16'h00C6, {7'h00, shp});
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("filter off", 16'h0000, {14'h0000, filt, tune});
    rd(5'h1D, 16'h0009);
    @(posedge clk);
    rxm <= 1'b0;
    wr(5'h02, 16'h5000);
    @(posedge clk);
    go <= 1'b1;
    n = 0;
    wait_on(2, 200);
    rng("launch delay", 75, 82);
    n = 0;
    wait_on(3, 100);
    rng("antenna lag", 60, 66);
    // steady ones, then steady zeros, through table and scaler
    for (int s = 1; s >= 0; s--)
    begin
      @(posedge clk);
      stb <= s[0];
      repeat (8)
      begin
        @(posedge clk);
        #1;
        n = 0;
        wait_on(2, 40);
      end
      repeat (12) @(posedge clk);
      #1;
      chk("table", s ? 16'h00C6 : 16'h013A, {7'h00, shp});
      chk("port two", s ? 16'h0031 : 16'h004E, {9'h000, vp2});
      chk("dac", s ? 16'h0108 : 16'h01B9, {7'h00, dac});
      chk("tx filter", 16'h0000, {15'h0000, filt});
    end
    @(posedge clk);
    go <= 1'b0;
    repeat (10) @(posedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
